// *** dv/i2c_sub_addressed_register_port_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2c_sub_addressed_register_port_test;
  import isarp_pkg::*;
  logic               clk = 1'b0;
  logic               link_clk = 1'b0;
  logic               reset = 1'b1;
  logic               req_valid = 1'b0;
  logic               req_ready, rsp_valid, rsp_nack, irq_n;
  isarp_op_e          req_op = OP_WRITE;
  isarp_byte_t        req_ptr = 8'h00, req_data = 8'h00, rsp_data;
  isarp_byte_t        status_in [NUM_STAT];
  isarp_byte_t        stat_exp [NUM_STAT];
  isarp_byte_t        cmd_out [NUM_CMD];
  isarp_byte_t        shadow [NUM_CMD];
  logic [NUM_IRQ-1:0] irq_event = '0;
  logic               power_lost = 1'b0, alt_lim = 1'b0;
  int                 error_cnt = 0, cmp_count = 0, cyc = 0, seed = 75, i;

  isarp_if bus_i ();
  isarp_host_end #(.QTR(10)) isarp_host_end_i (.bus(bus_i.host), .clk(clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_ptr(req_ptr),
    .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  isarp_dev_end isarp_dev_end_i (.bus(bus_i.dev), .link_clk(link_clk), .clk(clk), .reset(reset),
    .status_in(status_in), .irq_event(irq_event), .input_power_lost(power_lost),
    .resistor_programmed_limit_mode(alt_lim), .cmd_out(cmd_out), .irq_n(irq_n));
  isarp_chk isarp_chk_i (.link_clk(link_clk), .reset(reset), .scl(bus_i.scl), .sda(bus_i.sda),
    .host_scl_o(bus_i.host_scl_o), .host_scl_oe(bus_i.host_scl_oe),
    .dev_sda_o(bus_i.dev_sda_o), .dev_sda_oe(bus_i.dev_sda_oe));

  always #50 clk = ~clk;
  // Half of 125 ns; rising link clock edges never land on a system clock edge.
  always #62.5 link_clk = ~link_clk;

  //////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  function automatic isarp_byte_t rnd();
    int r;
    r = $random(seed);
    return r[7:0];
  endfunction

  function automatic isarp_byte_t exp_rd(input isarp_byte_t p);
    if (p <= SUB_CMD_LAST) return shadow[p[1:0]];
    if (p == SUB_IMR) return shadow[IMR_IDX];
    if (p >= SUB_STAT_FIRST && p <= SUB_STAT_LAST) return stat_exp[p[1:0] - 2'h3];
    return IDLE_BYTE;
  endfunction

  task automatic xfer(input isarp_op_e op, input isarp_byte_t ptr, input isarp_byte_t data);
    int n;
    @(negedge clk);
    req_op = op;
    req_ptr = ptr;
    req_data = data;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    check({7'h00, rsp_valid}, 8'h01);
    check({7'h00, rsp_nack}, 8'h00);
    repeat (20) @(negedge clk);
  endtask

  task automatic rd(input isarp_byte_t p);
    xfer(OP_READ, p, 8'h00);
    check(rsp_data, exp_rd(p));
  endtask

  task automatic pulse(input logic [NUM_IRQ-1:0] v);
    @(negedge clk);
    irq_event = v;
    @(negedge clk);
    irq_event = '0;
    repeat (5) @(negedge clk);
  endtask

  //////////////////////////////////////////////////////////////
  initial begin
    status_in = '{default: 8'h00};
    stat_exp = '{default: 8'h00};
    shadow = '{default: 8'h00};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (5) @(negedge clk);
    for (i = 0; i < 3; i++) begin
      shadow[i] = (i == 2) ? 8'h00 : rnd();
      xfer(OP_WRITE, i[7:0], shadow[i]);
      check(cmd_out[i], shadow[i]);
    end
    // Sub 0x07 is acked and dropped, so nothing visible moves.
    xfer(OP_WRITE, 8'h07, 8'hA5);
    for (i = 0; i < 3; i++) begin
      status_in[i] = rnd();
      stat_exp[i] = status_in[i];
    end
    for (i = 0; i < 9; i++) rd(i[7:0]);
    xfer(OP_PTR, 8'h01, 8'h00);
    for (i = 0; i < 2; i++) begin
      xfer(OP_RECV, 8'h00, 8'h00);
      check(rsp_data, shadow[1]);
    end
    pulse('1);
    check({7'h00, irq_n}, 8'h01);
    shadow[IMR_IDX] = 8'hFC;
    xfer(OP_WRITE, SUB_IMR, 8'hFC);
    check(cmd_out[IMR_IDX], 8'hFC);
    pulse(6'h01);
    check({7'h00, irq_n}, 8'h00);
    for (i = 0; i < 3; i++) status_in[i] = ~stat_exp[i];
    rd(SUB_STAT_FIRST);
    xfer(OP_WRITE, SUB_IMR, 8'hFC);
    check({7'h00, irq_n}, 8'h01);
    stat_exp = status_in;
    rd(SUB_STAT_LAST);
    for (i = 1; i >= 0; i--) begin
      power_lost = 1'b0;
      alt_lim = i[0];
      repeat (40) @(negedge clk);
      power_lost = 1'b1;
      repeat (40) @(negedge clk);
      shadow[USB_LIM_IDX][4:0] = i[0] ? LIM_DEF_ALT : LIM_DEF_LOW;
      shadow[ADP_LIM_IDX][4:0] = i[0] ? LIM_DEF_ALT : LIM_DEF_LOW;
      check(cmd_out[USB_LIM_IDX], shadow[USB_LIM_IDX]);
      check(cmd_out[ADP_LIM_IDX], shadow[ADP_LIM_IDX]);
      rd(8'h00);
    end
    power_lost = 1'b0;
    pulse(6'h3F);
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (5) @(negedge clk);
    check({7'h00, irq_n}, 8'h01);
    for (i = 0; i < 4; i++) check(cmd_out[i], CMD_RST);
    xfer(OP_RECV, 8'h00, 8'h00);
    check(rsp_data, CMD_RST);
    check(cmd_out[1], CMD_RST);
    wrap_up();
  end
endmodule
`default_nettype wire

// *** dv/isarp_chk_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module isarp_chk (
  // Link clock and reset.
  input wire logic link_clk,
  input wire logic reset,
  // Resolved lines and drivers.
  input wire logic scl,
  input wire logic sda,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (reset);

  // Counts how long the device holds data low without a break.
  logic [8:0] drv_q;
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      drv_q <= 9'h000;
    end else if (dev_sda_oe) begin
      drv_q <= drv_q + 9'h001;
    end else begin
      drv_q <= 9'h000;
    end
  end

  //////////////////////////////////////////////////////////////
  property p_dev_od; dev_sda_oe |-> !dev_sda_o; endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drove data high");
  property p_ack_stable; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("device data moved with clock high");
  property p_scl_host; !scl |-> host_scl_oe && !host_scl_o; endproperty
  a_scl_host: assert property (p_scl_host) else $error("clock low without master");
  property p_stop_idle; scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*8]; endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("device drives after stop");
  property p_drive_len; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
  a_drive_len: assert property (p_drive_len) else $error("device pulse too short");
  // A zero byte after the ack is nine bit slots of 32 link cycles.
  property p_drive_max; drv_q <= 9'h128; endproperty
  a_drive_max: assert property (p_drive_max) else $error("device kept data past eighth bit");
  property p_sda_edge; scl && $past(scl) && $changed(sda) |-> !dev_sda_oe && !$past(dev_sda_oe); endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("device made start or stop");
  property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("clock high too short");
  c_ack: cover property ($rose(dev_sda_oe));
  c_start: cover property (scl && $past(scl) && $fell(sda));
  c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule
`default_nettype wire

// *** rtl/isarp_dev_end.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R1] Acknowledge write address and every written byte.
// [R2] Receiver holds data low through acknowledge pulse.
// [R3] Release data line after eighth read bit.
// [R4] Answer fixed address, both write and read.
// [R5] Master sets direction bit, zero writes.
// [R6] Four command and three status registers.
// [R7] First written byte is pointer, kept afterwards.
// [R8] Load pointer when acknowledging its byte.
// [R9] Data byte goes to pending, not active.
// [R10] Alternate pointer and data bytes without limit.
// [R11] Repeated start keeps pending data unapplied.
// [R12] STOP copies all pending into command registers.
// [R13] Shift selected byte MSB first, then ones.
// [R14] In reads acknowledge only the address.
// [R15] Master rewrites pointer before reading elsewhere.
// [R16] Read of modified command returns pending value.
// [R17] Power loss resets both current limit fields.
// [R18] Status snapshot taken at read address acknowledge.
// [R19] Unmasked event asserts interrupt, freezes status.
// [R20] Interrupt clear releases frozen status.
// [R21] Data written to 0x06 clears interrupt.
// [R22] Never drive or stretch the serial clock.
// [R23] Lockout reset clears port and configuration.
// [R24] Pointer and pending flags reset to zero.
module isarp_dev_end (
  // Serial link.
  isarp_if.dev                   bus,
  input  wire logic              link_clk,
  // System side.
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire isarp_pkg::isarp_byte_t status_in [isarp_pkg::NUM_STAT],
  input  wire logic [isarp_pkg::NUM_IRQ-1:0] irq_event,
  input  wire logic              input_power_lost,
  input  wire logic              resistor_programmed_limit_mode,
  // Outputs.
  output var isarp_pkg::isarp_byte_t cmd_out [isarp_pkg::NUM_CMD],
  output logic                   irq_n
);
  import isarp_pkg::*;

  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_ADDR = 5'b00010,
    L_WRB  = 5'b00100,
    L_ACK  = 5'b01000,
    L_RDB  = 5'b10000
  } isarp_lst_e;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pin and handshake synchronisers.
  logic [4:0]   pin_m_q;
  logic [4:0]   pin_s_q;
  logic         scl_p_q;
  logic         sda_p_q;
  logic         pwr_p_q;
  logic         ack_p_q;
  logic         scl_s;
  logic         sda_s;
  logic         pwr_s;
  logic         alt_s;
  logic         ack_s;
  logic         snap_ack_tgl_q;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      pin_m_q <= 5'h18;
      pin_s_q <= 5'h18;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      pwr_p_q <= 1'b0;
      ack_p_q <= 1'b0;
    end else begin
      pin_m_q <= {bus.scl, bus.sda, input_power_lost, resistor_programmed_limit_mode, snap_ack_tgl_q};
      pin_s_q <= pin_m_q;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      pwr_p_q <= pwr_s;
      ack_p_q <= ack_s;
    end
  end

  assign {scl_s, sda_s, pwr_s, alt_s, ack_s} = pin_s_q;

  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign rise_c  = scl_s & ~scl_p_q;
  assign fall_c  = ~scl_s & scl_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: byte engine.
  isarp_lst_e   st_q;
  logic [3:0]   cnt_q;
  isarp_byte_t  rx_q;
  isarp_byte_t  tx_q;
  logic         rw_q;
  logic         drive_q;
  logic         byte_done_c;
  logic         addr_hit_c;
  logic         data_ack_c;
  isarp_byte_t  rd_byte_c;

  assign byte_done_c = fall_c && (cnt_q == ACK_BIT) && (st_q == L_ADDR || st_q == L_WRB);
  // [R4] Address match both forms.
  assign addr_hit_c  = byte_done_c && (st_q == L_ADDR) && (rx_q[7:1] == DEV_ADDR);
  assign data_ack_c  = byte_done_c && (st_q == L_WRB);

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      st_q    <= L_IDLE;
      cnt_q   <= 4'h0;
      rx_q    <= 8'h00;
      tx_q    <= IDLE_BYTE;
      rw_q    <= 1'b0;
      drive_q <= 1'b0;
    end else if (stop_c) begin
      st_q    <= L_IDLE;
      drive_q <= 1'b0;
    end else if (start_c) begin
      st_q    <= L_ADDR;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else begin
      unique case (st_q)
        L_ADDR, L_WRB: begin
          if (rise_c) begin
            rx_q  <= {rx_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
          end
          // [R1] Ack address and data.
          if (addr_hit_c || data_ack_c) begin
            st_q    <= L_ACK;
            drive_q <= 1'b1;
          end else if (byte_done_c) begin
            st_q <= L_IDLE;
          end
          if (addr_hit_c) begin
            rw_q <= rx_q[0];
          end
        end
        L_ACK: begin
          // [R2] Hold low until the ack pulse falls.
          if (fall_c) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              // [R13] Load selected byte MSB first.
              st_q    <= L_RDB;
              tx_q    <= rd_byte_c;
              drive_q <= ~rd_byte_c[7];
            end else begin
              st_q    <= L_WRB;
              drive_q <= 1'b0;
            end
          end
        end
        L_RDB: begin
          // [R3] Ones shift in, so the line is released after bit eight.
          // [R14] No acknowledge is ever driven here.
          if (fall_c) begin
            tx_q    <= {tx_q[6:0], 1'b1};
            drive_q <= ~tx_q[6];
          end
        end
        L_IDLE: begin
        end
      endcase
    end
  end

  // [R22] Only the data line has a driver here.
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = drive_q;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pointer, pending data and command registers.
  isarp_byte_t  ptr_q;
  logic         ptr_next_q;
  isarp_byte_t  pend_q  [NUM_CMD];
  logic [NUM_CMD-1:0] pend_v_q;
  isarp_byte_t  cmd_q   [NUM_CMD];
  isarp_byte_t  snap_q  [NUM_STAT];
  isarp_byte_t  snap_hold_q [NUM_STAT];
  logic         cmd_hit_c;
  logic [1:0]   cmd_idx_c;
  logic         stat_hit_c;
  logic [1:0]   stat_idx_c;
  logic         pwr_rise_c;
  logic         store_c;

  // [R6] Pointer decode to seven registers.
  assign cmd_hit_c  = (ptr_q <= SUB_CMD_LAST) || (ptr_q == SUB_IMR);
  assign cmd_idx_c  = (ptr_q == SUB_IMR) ? IMR_IDX : ptr_q[1:0];
  assign stat_hit_c = (ptr_q >= SUB_STAT_FIRST) && (ptr_q <= SUB_STAT_LAST);
  assign stat_idx_c = 2'(ptr_q - SUB_STAT_FIRST);
  assign pwr_rise_c = pwr_s & ~pwr_p_q;
  assign store_c    = data_ack_c && !ptr_next_q;

  // [R16] Pending value wins while modified.
  assign rd_byte_c = cmd_hit_c ? (pend_v_q[cmd_idx_c] ? pend_q[cmd_idx_c] : cmd_q[cmd_idx_c])
                   : stat_hit_c ? snap_q[stat_idx_c] : IDLE_BYTE;

  // [R24] Pointer and byte position clear on reset.
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      ptr_q      <= 8'h00;
      ptr_next_q <= 1'b0;
    end else begin
      // [R10] Odd bytes pointer, even bytes data.
      if (addr_hit_c) begin
        ptr_next_q <= 1'b1;
      end else if (data_ack_c) begin
        ptr_next_q <= ~ptr_next_q;
      end
      // [R8] Pointer loads at its ack.
      // [R7] It persists across transactions.
      if (data_ack_c && ptr_next_q) begin
        ptr_q <= rx_q;
      end
    end
  end

  for (genvar g = 0; g < NUM_CMD; g++) begin : g_cmd
    always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
        pend_q[g]   <= CMD_RST;
        pend_v_q[g] <= 1'b0;
        cmd_q[g]    <= CMD_RST;
      end else begin
        // [R9] Data held pending at its ack.
        if (store_c && cmd_hit_c && cmd_idx_c == 2'(g)) begin
          pend_q[g]   <= rx_q;
          pend_v_q[g] <= 1'b1;
        end else if (stop_c) begin
          pend_v_q[g] <= 1'b0;
        end
        // [R12] Group update at STOP.
        // [R11] A repeated start commits nothing.
        if (stop_c && pend_v_q[g]) begin
          cmd_q[g] <= pend_q[g];
        end
        // [R17] Limit fields fall to default.
        if (pwr_rise_c && (2'(g) == USB_LIM_IDX || 2'(g) == ADP_LIM_IDX)) begin
          cmd_q[g][LIM_W-1:0] <= alt_s ? LIM_DEF_ALT : LIM_DEF_LOW;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: event toggles towards the system clock.
  logic commit_tgl_q;
  logic clr_tgl_q;
  logic req_tgl_q;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      commit_tgl_q <= 1'b0;
      clr_tgl_q    <= 1'b0;
      req_tgl_q    <= 1'b0;
      for (int i = 0; i < NUM_STAT; i++) begin
        snap_q[i] <= 8'h00;
      end
    end else begin
      if ((stop_c && |pend_v_q) || pwr_rise_c) begin
        commit_tgl_q <= ~commit_tgl_q;
      end
      // [R21] Interrupt clear on data ack.
      if (store_c && ptr_q == SUB_IMR) begin
        clr_tgl_q <= ~clr_tgl_q;
      end
      // [R18] Snapshot asked at read address ack.
      if (addr_hit_c && rx_q[0]) begin
        req_tgl_q <= ~req_tgl_q;
      end
      if (ack_s != ack_p_q) begin
        snap_q <= snap_hold_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System domain. The snapshot answer takes about 1 us, far below one bit time.
  logic [2:0]   x_m_q;
  logic [2:0]   x_s_q;
  logic [2:0]   x_p_q;
  logic         irq_pend_q;
  isarp_byte_t  frozen_q    [NUM_STAT];
  logic         ev_c;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      x_m_q <= 3'h0;
      x_s_q <= 3'h0;
      x_p_q <= 3'h0;
    end else begin
      x_m_q <= {commit_tgl_q, clr_tgl_q, req_tgl_q};
      x_s_q <= x_m_q;
      x_p_q <= x_s_q;
    end
  end

  assign ev_c = |(irq_event & cmd_out[IMR_IDX][IMR_LSB +: NUM_IRQ]);

  // [R23] Lockout masks all and drops pending.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_out        <= '{default: CMD_RST};
      irq_pend_q     <= 1'b0;
      frozen_q       <= '{default: 8'h00};
      snap_hold_q    <= '{default: 8'h00};
      snap_ack_tgl_q <= 1'b0;
    end else begin
      // Committed words are stable long before the toggle lands.
      if (x_s_q[2] != x_p_q[2]) begin
        cmd_out <= cmd_q;
      end
      // [R19] Event pulls the line low and freezes.
      // [R20] Clear releases frozen status; set wins.
      if (ev_c) begin
        irq_pend_q <= 1'b1;
        if (!irq_pend_q || x_s_q[1] != x_p_q[1]) begin
          frozen_q <= status_in;
        end
      end else if (x_s_q[1] != x_p_q[1]) begin
        irq_pend_q <= 1'b0;
      end
      if (x_s_q[0] != x_p_q[0]) begin
        snap_hold_q    <= irq_pend_q ? frozen_q : status_in;
        snap_ack_tgl_q <= ~snap_ack_tgl_q;
      end
    end
  end

  assign irq_n = ~irq_pend_q;

endmodule
`default_nettype wire

// *** rtl/isarp_host_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module isarp_host_end #(
  parameter int QTR = isarp_pkg::QTR_CYC
) (
  // Serial link.
  isarp_if.host                  bus,
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              reset,
  // Request.
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire isarp_pkg::isarp_op_e   req_op,
  input  wire isarp_pkg::isarp_byte_t req_ptr,
  input  wire isarp_pkg::isarp_byte_t req_data,
  // Answer.
  output logic                   rsp_valid,
  output isarp_pkg::isarp_byte_t rsp_data,
  output logic                   rsp_nack
);
  import isarp_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_RUN  = 2'b10
  } isarp_hst_e;

  // Program of bus items for each operation.
  function automatic isarp_item_s item_f(input isarp_op_e op, input logic [2:0] step,
                                         input isarp_byte_t ptr, input isarp_byte_t data);
    isarp_item_s it;
    it = '{kind: IT_END, data: IDLE_BYTE};
    if (step == 3'h0) begin
      it.kind = IT_START;
    end else begin
      unique case (op)
        OP_WRITE: begin
          unique case (step)
            3'h1: it = '{kind: IT_TX, data: WR_ADDR_BYTE};
            3'h2: it = '{kind: IT_TX, data: ptr};
            3'h3: it = '{kind: IT_TX, data: data};
            3'h4: it.kind = IT_STOP;
            default: it.kind = IT_END;
          endcase
        end
        // A pointer write, a repeated start, then the read address.
        OP_READ: begin
          unique case (step)
            3'h1: it = '{kind: IT_TX, data: WR_ADDR_BYTE};
            3'h2: it = '{kind: IT_TX, data: ptr};
            3'h3: it.kind = IT_START;
            // [R5] Direction bit set.
            3'h4: it = '{kind: IT_TX, data: RD_ADDR_BYTE};
            3'h5: it.kind = IT_RX;
            3'h6: it.kind = IT_STOP;
            default: it.kind = IT_END;
          endcase
        end
        OP_RECV: begin
          unique case (step)
            3'h1: it = '{kind: IT_TX, data: RD_ADDR_BYTE};
            3'h2: it.kind = IT_RX;
            3'h3: it.kind = IT_STOP;
            default: it.kind = IT_END;
          endcase
        end
        OP_PTR: begin
          unique case (step)
            3'h1: it = '{kind: IT_TX, data: WR_ADDR_BYTE};
            3'h2: it = '{kind: IT_TX, data: ptr};
            3'h3: it.kind = IT_STOP;
            default: it.kind = IT_END;
          endcase
        end
      endcase
    end
    return it;
  endfunction

  isarp_hst_e   st_q;
  isarp_op_e    op_q;
  isarp_byte_t  ptr_q;
  isarp_byte_t  data_q;
  logic [2:0]   step_q;
  logic [1:0]   ph_q;
  logic [$clog2(QTR+1)-1:0] div_q;
  logic [3:0]   bit_q;
  isarp_byte_t  rx_q;
  logic         nack_q;
  logic         scl_low_q;
  logic         sda_low_q;
  logic [1:0]   m_q;
  logic [1:0]   s_q;
  logic         tick_c;
  isarp_item_s  cur_c;

  // The wait on a high clock lets a stretching target hold the bit.
  assign cur_c  = item_f(op_q, step_q, ptr_q, data_q);
  assign tick_c = (st_q == H_RUN) && (div_q == ($clog2(QTR+1))'(QTR - 1)) && (ph_q != PH_SAMPLE || s_q[1]);
  assign req_ready = (st_q == H_IDLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      m_q   <= 2'h3;
      s_q   <= 2'h3;
      div_q <= '0;
    end else begin
      m_q <= {bus.scl, bus.sda};
      s_q <= m_q;
      if (st_q != H_RUN || tick_c) begin
        div_q <= '0;
      end else if (div_q != ($clog2(QTR+1))'(QTR - 1)) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q      <= H_IDLE;
      op_q      <= OP_WRITE;
      ptr_q     <= 8'h00;
      data_q    <= 8'h00;
      step_q    <= 3'h0;
      ph_q      <= PH_SET;
      bit_q     <= 4'h0;
      rx_q      <= 8'h00;
      nack_q    <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_nack  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (req_valid) begin
            st_q   <= H_RUN;
            op_q   <= req_op;
            ptr_q  <= req_ptr;
            data_q <= req_data;
            step_q <= 3'h0;
            ph_q   <= PH_SET;
            bit_q  <= 4'h0;
            nack_q <= 1'b0;
          end
        end
        H_RUN: begin
          if (cur_c.kind == IT_END) begin
            st_q      <= H_IDLE;
            rsp_valid <= 1'b1;
            rsp_data  <= rx_q;
            rsp_nack  <= nack_q;
          end else if (tick_c) begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              PH_SET: begin
                if (cur_c.kind == IT_START) begin
                  sda_low_q <= 1'b0;
                end else if (cur_c.kind == IT_STOP) begin
                  sda_low_q <= 1'b1;
                end else begin
                  // The acknowledge slot of a read is left high: a NACK.
                  sda_low_q <= (cur_c.kind == IT_TX) && (bit_q != ACK_BIT) && !cur_c.data[~bit_q[2:0]];
                end
              end
              PH_RISE: begin
                scl_low_q <= 1'b0;
              end
              PH_SAMPLE: begin
                if (cur_c.kind == IT_START) begin
                  sda_low_q <= 1'b1;
                end else if (cur_c.kind == IT_STOP) begin
                  sda_low_q <= 1'b0;
                end else if (bit_q != ACK_BIT) begin
                  rx_q <= {rx_q[6:0], s_q[0]};
                end else if (cur_c.kind == IT_TX && s_q[0]) begin
                  nack_q <= 1'b1;
                end
              end
              PH_FALL: begin
                if (cur_c.kind != IT_STOP) begin
                  scl_low_q <= 1'b1;
                end
                if (cur_c.kind == IT_TX || cur_c.kind == IT_RX) begin
                  bit_q <= (bit_q == ACK_BIT) ? 4'h0 : bit_q + 4'h1;
                  if (bit_q == ACK_BIT) begin
                    step_q <= step_q + 3'h1;
                  end
                end else begin
                  step_q <= step_q + 3'h1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign bus.host_scl_o  = 1'b0;
  assign bus.host_scl_oe = scl_low_q;
  assign bus.host_sda_o  = 1'b0;
  assign bus.host_sda_oe = sda_low_q;

endmodule
`default_nettype wire

// *** rtl/isarp_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface isarp_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Open-drain lines: pulled up unless some enabled driver pulls low.
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// *** rtl/isarp_pkg.sv ***
package isarp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register space.
  localparam int          NUM_CMD        = 4;
  localparam int          NUM_STAT       = 3;
  localparam int          NUM_IRQ        = 6;
  localparam logic [6:0]  DEV_ADDR       = 7'h09;
  localparam logic [7:0]  WR_ADDR_BYTE   = 8'h12;
  localparam logic [7:0]  RD_ADDR_BYTE   = 8'h13;
  localparam logic [7:0]  SUB_CMD_LAST   = 8'h02;
  localparam logic [7:0]  SUB_STAT_FIRST = 8'h03;
  localparam logic [7:0]  SUB_STAT_LAST  = 8'h05;
  localparam logic [7:0]  SUB_IMR        = 8'h06;
  localparam logic [1:0]  IMR_IDX        = 2'h3;
  localparam int          IMR_LSB        = 2;
  localparam logic [1:0]  USB_LIM_IDX    = 2'h0;
  localparam logic [1:0]  ADP_LIM_IDX    = 2'h1;
  localparam int          LIM_W          = 5;
  localparam logic [4:0]  LIM_DEF_LOW    = 5'h00;
  localparam logic [4:0]  LIM_DEF_ALT    = 5'h1F;
  localparam logic [7:0]  CMD_RST        = 8'h00;
  localparam logic [7:0]  IDLE_BYTE      = 8'hFF;
  localparam logic [3:0]  ACK_BIT        = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Timing of the serial clock made by the master end.
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          SCL_PERIOD_NS  = 10000;
  localparam int          QTR_CYC        = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [1:0]  PH_SET         = 2'h0;
  localparam logic [1:0]  PH_RISE        = 2'h1;
  localparam logic [1:0]  PH_SAMPLE      = 2'h2;
  localparam logic [1:0]  PH_FALL        = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef logic [7:0] isarp_byte_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ  = 2'h1,
    OP_RECV  = 2'h2,
    OP_PTR   = 2'h3
  } isarp_op_e;

  typedef enum logic [2:0] {
    IT_START = 3'h0,
    IT_TX    = 3'h1,
    IT_RX    = 3'h2,
    IT_STOP  = 3'h3,
    IT_END   = 3'h4
  } isarp_item_e;

  typedef struct packed {
    isarp_item_e kind;
    isarp_byte_t data;
  } isarp_item_s;

endpackage
